/* File: inc/dir_pkg.sv */
// constants and types shared by the distributed interrupt relay
package dir_pkg;

  // broadcast code on the link side
  typedef struct packed {
    logic [1:0] kind;
    logic ack;
    logic [4:0] id;
  } dir_code_s;

  localparam logic [1:0] BC_KIND_IRQ = 2'b10;
  localparam int ID_W = 5;

  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PORTEN = 8'h04;
  localparam logic [7:0] REG_TMO_PLAIN = 8'h08;
  localparam logic [7:0] REG_TMO_ACK = 8'h0C;
  localparam logic [7:0] REG_RELAY = 8'h10;

  // control register fields
  localparam int CTRL_W = 6;
  localparam int CTRL_EN = 0;
  localparam int CTRL_ACKMODE = 1;
  localparam int CTRL_NODE_SEND = 2;
  localparam int CTRL_NODE_RECV = 3;
  localparam int CTRL_NODE_ASEND = 4;
  localparam int CTRL_NODE_ARECV = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // port enable register: receive enables low, send enables from here
  localparam int PORTEN_TX_LSB = 16;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic HRESP_OKAY = 1'b0;

  // default timeout after reset
  localparam int CLK_PERIOD_NS = 20;
  localparam int TMO_DEF_NS = 100000;
  localparam int TMO_DEF_CYC = TMO_DEF_NS / CLK_PERIOD_NS;

endpackage : dir_pkg

/* File: rtl/dir_relay.sv */
// distributed interrupt relay switch with host end-point and AHB-Lite registers
// How it works
// R1: interrupt code carries identifier 0..31 in bits 0-4, bit 5 zero.
// R2: acknowledgement code sets bit 5, same identifier as its interrupt.
// R3: block runs plain or acknowledgement mode, selected by a control bit.
// R4: with support disabled, received codes and host requests are ignored.
// R5: host interrupt request sends an interrupt code with that identifier.
// R6: received interrupt code is reported to the host with its identifier.
// R7: host spaces repeated plain-mode interrupts beyond network propagation time.
// R8: host spaces repeated ack-mode interrupts beyond propagation plus ack return.
// R9: every port has separate receive and send enable bits.
// R10: receive-disabled port drops codes; send-disabled port never transmits them.
// R11: relay flag register holds one bit per identifier, width configurable.
// R12: reset clears all relay flags.
// R13: every relay flag has its own timer with configurable interval.
// R14: software sets plain interval above worst-case interrupt propagation.
// R15: software sets ack interval above propagation, ack generation and return.
// R16: identifier beyond a narrowed relay register is dropped.
// R17: clear flag: set it, start timer, forward to other send-enabled ports.
// R18: flag already set: drop the code.
// R19: timer expiry clears its relay flag.
// R20: host ack request sends ack code; discarded when ack sending disabled.
// R21: host waits between interrupt arrival and ack within set bounds.
// R22: received ack reported to host; dropped when ack receive disabled.
// R23: interrupt and ack codes use broadcast type binary 10.
// R24: pending ack codes go to the link before pending interrupt codes.
// R25: timers count down in clock cycles from the interval, expire at zero.
`timescale 1ns/1ns
module dir_relay #(
  parameter int NPORTS = 4,
  parameter int RELAY_BITS = 32,
  parameter int TMO_W = 32,
  parameter logic [TMO_W-1:0] TMO_RESET = TMO_W'(dir_pkg::TMO_DEF_CYC)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // switch ports, receive side
  input wire logic [NPORTS-1:0] rxValid,
  input wire dir_pkg::dir_code_s [NPORTS-1:0] rxCode,
  output logic [NPORTS-1:0] rxReady,
  // switch ports, send side
  output logic [NPORTS-1:0] txValid,
  output dir_pkg::dir_code_s txCode,
  // node end-point link
  output logic ndTxValid,
  output dir_pkg::dir_code_s ndTxCode,
  input wire logic ndTxReady,
  input wire logic ndRxValid,
  input wire dir_pkg::dir_code_s ndRxCode,
  // host requests
  input wire logic hostIntReq,
  input wire logic [4:0] hostIntId,
  input wire logic hostAckReq,
  input wire logic [4:0] hostAckId,
  output logic hostIntBusy,
  output logic hostAckBusy,
  // host notifications
  output logic hostIntNote,
  output logic hostAckNote,
  output logic [4:0] hostNoteId
);

  typedef struct packed {
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic dWrite;
    logic [dir_pkg::ADDR_W-1:0] dAddr;
    logic [dir_pkg::CTRL_W-1:0] ctrl;
    logic [NPORTS-1:0] rxEn;
    logic [NPORTS-1:0] txEn;
    logic [TMO_W-1:0] tmoPlain;
    logic [TMO_W-1:0] tmoAck;
    logic [RELAY_BITS-1:0] relay;
    logic [RELAY_BITS-1:0][TMO_W-1:0] timer;
    logic [NPORTS-1:0] slotFree;
    dir_pkg::dir_code_s [NPORTS-1:0] slot;
    logic [NPORTS-1:0] txValid;
    dir_pkg::dir_code_s txCode;
    logic intPend;
    logic [4:0] intId;
    logic ackPend;
    logic [4:0] ackId;
    logic ndTxValid;
    dir_pkg::dir_code_s ndTxCode;
    logic hostIntNote;
    logic hostAckNote;
    logic [4:0] hostNoteId;
  } dir_state_s;

  dir_state_s st_r;
  dir_state_s st_nxt;

  // observation points of the relay decision
  logic fwdGo;
  logic dropSet;
  logic dropRange;
  logic [NPORTS-1:0] fwdMask;
  logic [4:0] fwdId;
  logic enabled;
  logic ackMode;

  assign enabled = st_r.ctrl[dir_pkg::CTRL_EN];
  assign ackMode = st_r.ctrl[dir_pkg::CTRL_ACKMODE];

  always_comb begin
    logic served;
    logic [TMO_W-1:0] interval;
    dir_pkg::dir_code_s c;
    served = 1'b0;
    c = '0;
    interval = ackMode ? st_r.tmoAck : st_r.tmoPlain; // R3 R13
    st_nxt = st_r;
    st_nxt.txValid = '0;
    st_nxt.hostIntNote = 1'b0;
    st_nxt.hostAckNote = 1'b0;
    fwdGo = 1'b0;
    dropSet = 1'b0;
    dropRange = 1'b0;
    fwdMask = '0;
    fwdId = '0;

    // register writes in the data phase
    if (st_r.dWrite) begin
      unique case (st_r.dAddr)
        dir_pkg::REG_CTRL: st_nxt.ctrl = hwdata[dir_pkg::CTRL_W-1:0]; // R3
        dir_pkg::REG_PORTEN: begin
          st_nxt.rxEn = hwdata[NPORTS-1:0]; // R9
          st_nxt.txEn = hwdata[dir_pkg::PORTEN_TX_LSB +: NPORTS]; // R9
        end
        dir_pkg::REG_TMO_PLAIN: st_nxt.tmoPlain = hwdata[TMO_W-1:0]; // R13
        dir_pkg::REG_TMO_ACK: st_nxt.tmoAck = hwdata[TMO_W-1:0]; // R13
        default: ;
      endcase
    end

    // per-flag timeout timers
    for (int i = 0; i < RELAY_BITS; i++) begin
      if (st_r.relay[i]) begin
        if (st_r.timer[i] == '0) begin
          st_nxt.relay[i] = 1'b0; // R19
        end else begin
          st_nxt.timer[i] = st_r.timer[i] - TMO_W'(1); // R25
        end
      end
    end

    // one-entry holding slot per receive port
    for (int p = 0; p < NPORTS; p++) begin
      if (!st_r.slotFree[p] && !served) begin
        served = 1'b1;
        st_nxt.slotFree[p] = 1'b1;
        c = st_r.slot[p];
        if (enabled && st_r.rxEn[p] && c.kind == dir_pkg::BC_KIND_IRQ && !c.ack) begin // R4 R10 R23
          if (int'(c.id) >= RELAY_BITS) begin
            dropRange = 1'b1; // R16
          end else if (st_r.relay[c.id]) begin
            dropSet = 1'b1; // R18
          end else begin
            fwdGo = 1'b1;
            fwdId = c.id;
            fwdMask = st_r.txEn & ~(NPORTS'(1) << p); // R10 R17
            st_nxt.relay[c.id] = 1'b1; // R17
            st_nxt.timer[c.id] = interval; // R17 R25
            st_nxt.txValid = fwdMask;
            st_nxt.txCode = c;
          end
        end
      end
    end
    for (int p = 0; p < NPORTS; p++) begin
      if (rxValid[p] && st_r.slotFree[p]) begin
        st_nxt.slot[p] = rxCode[p];
        st_nxt.slotFree[p] = 1'b0;
      end
    end

    // host requests into the end-point
    if (hostIntReq && !st_r.intPend && enabled && st_r.ctrl[dir_pkg::CTRL_NODE_SEND]) begin // R4 R5
      st_nxt.intPend = 1'b1;
      st_nxt.intId = hostIntId;
    end
    if (hostAckReq && !st_r.ackPend && enabled && ackMode && st_r.ctrl[dir_pkg::CTRL_NODE_ASEND]) begin // R20
      st_nxt.ackPend = 1'b1;
      st_nxt.ackId = hostAckId;
    end

    // end-point transmit, acks ahead of interrupts
    if (st_r.ndTxValid && ndTxReady) begin
      st_nxt.ndTxValid = 1'b0;
    end
    if (!st_r.ndTxValid || ndTxReady) begin
      if (st_r.ackPend) begin // R24
        st_nxt.ackPend = 1'b0;
        st_nxt.ndTxValid = 1'b1;
        st_nxt.ndTxCode = '{kind: dir_pkg::BC_KIND_IRQ, ack: 1'b1, id: st_r.ackId}; // R2 R23
      end else if (st_r.intPend) begin
        st_nxt.intPend = 1'b0;
        st_nxt.ndTxValid = 1'b1;
        st_nxt.ndTxCode = '{kind: dir_pkg::BC_KIND_IRQ, ack: 1'b0, id: st_r.intId}; // R1 R23
      end
    end

    // end-point receive, reported to the host
    if (ndRxValid && enabled && ndRxCode.kind == dir_pkg::BC_KIND_IRQ) begin // R4 R23
      if (!ndRxCode.ack && st_r.ctrl[dir_pkg::CTRL_NODE_RECV]) begin
        st_nxt.hostIntNote = 1'b1; // R6
        st_nxt.hostNoteId = ndRxCode.id;
      end else if (ndRxCode.ack && ackMode && st_r.ctrl[dir_pkg::CTRL_NODE_ARECV]) begin
        st_nxt.hostAckNote = 1'b1; // R22
        st_nxt.hostNoteId = ndRxCode.id;
      end
    end

    // AHB address phase; read data from the updated copy, relay flags from the current one
    st_nxt.dWrite = 1'b0;
    st_nxt.hready = 1'b1;
    st_nxt.hresp = dir_pkg::HRESP_OKAY;
    if (hsel && htrans == dir_pkg::HTRANS_NONSEQ && hready) begin
      st_nxt.dWrite = hwrite && hsize == dir_pkg::HSIZE_WORD;
      st_nxt.dAddr = haddr[dir_pkg::ADDR_W-1:0];
      if (!hwrite) begin
        st_nxt.hrdata = '0;
        unique case (haddr[dir_pkg::ADDR_W-1:0])
          dir_pkg::REG_CTRL: st_nxt.hrdata[dir_pkg::CTRL_W-1:0] = st_nxt.ctrl;
          dir_pkg::REG_PORTEN: begin
            st_nxt.hrdata[NPORTS-1:0] = st_nxt.rxEn;
            st_nxt.hrdata[dir_pkg::PORTEN_TX_LSB +: NPORTS] = st_nxt.txEn;
          end
          dir_pkg::REG_TMO_PLAIN: st_nxt.hrdata[TMO_W-1:0] = st_nxt.tmoPlain;
          dir_pkg::REG_TMO_ACK: st_nxt.hrdata[TMO_W-1:0] = st_nxt.tmoAck;
          dir_pkg::REG_RELAY: st_nxt.hrdata[RELAY_BITS-1:0] = st_r.relay; // R11
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0; // R12
      st_r.hready <= 1'b1;
      st_r.slotFree <= '1;
      st_r.ctrl <= dir_pkg::CTRL_RST;
      st_r.tmoPlain <= TMO_RESET;
      st_r.tmoAck <= TMO_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.hready;
  assign hresp = st_r.hresp;
  assign hrdata = st_r.hrdata;
  assign rxReady = st_r.slotFree;
  assign txValid = st_r.txValid;
  assign txCode = st_r.txCode;
  assign ndTxValid = st_r.ndTxValid;
  assign ndTxCode = st_r.ndTxCode;
  assign hostIntBusy = st_r.intPend; // R7 R8 R21
  assign hostAckBusy = st_r.ackPend;
  assign hostIntNote = st_r.hostIntNote;
  assign hostAckNote = st_r.hostAckNote;
  assign hostNoteId = st_r.hostNoteId;

  // checks
  property p_reset_clear;
    @(posedge clk_sys) $past(srst) |-> st_r.relay == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("relay flags not clear after reset"); // R12

  property p_forward;
    @(posedge clk_sys) disable iff (srst)
      fwdGo |=> st_r.relay[$past(fwdId)] && txValid == $past(fwdMask) && txCode.id == $past(fwdId);
  endproperty
  a_forward: assert property (p_forward) else $error("forward did not set flag or ports"); // R17

  property p_drop_set;
    @(posedge clk_sys) disable iff (srst) (dropSet || dropRange) |=> txValid == '0;
  endproperty
  a_drop_set: assert property (p_drop_set) else $error("dropped code was forwarded"); // R18

  property p_send_en;
    @(posedge clk_sys) disable iff (srst) (txValid & ~$past(st_r.txEn)) == '0;
  endproperty
  a_send_en: assert property (p_send_en) else $error("code sent on send-disabled port"); // R10

  // every flag's timer, not only the first
  for (genvar b = 0; b < RELAY_BITS; b++) begin : g_timer
    property p_expire;
      @(posedge clk_sys) disable iff (srst) st_r.relay[b] && st_r.timer[b] == '0 |=> !st_r.relay[b];
    endproperty
    a_expire: assert property (p_expire) else $error("expired flag not cleared"); // R19

    property p_countdown;
      @(posedge clk_sys) disable iff (srst)
        st_r.relay[b] && st_r.timer[b] != '0 |=> st_r.timer[b] == $past(st_r.timer[b]) - TMO_W'(1);
    endproperty
    a_countdown: assert property (p_countdown) else $error("timer did not count down by one"); // R25
  end

  for (genvar p = 0; p < NPORTS; p++) begin : g_slot
    property p_slot_take;
      @(posedge clk_sys) disable iff (srst) rxValid[p] && rxReady[p] |=> !rxReady[p];
    endproperty
    a_slot_take: assert property (p_slot_take) else $error("offered code not taken into its slot"); // R17
  end

  property p_ack_first;
    @(posedge clk_sys) disable iff (srst)
      st_r.ackPend && st_r.intPend && (!ndTxValid || ndTxReady) |=> ndTxValid && ndTxCode.ack && !st_r.ackPend;
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("interrupt code passed ahead of ack"); // R24

  property p_code_form;
    @(posedge clk_sys) disable iff (srst)
      (!ndTxValid || ndTxReady) && (st_r.ackPend || st_r.intPend) |=> ndTxValid
        && ndTxCode.kind == dir_pkg::BC_KIND_IRQ && ndTxCode.ack == $past(st_r.ackPend)
        && ndTxCode.id == ($past(st_r.ackPend) ? $past(st_r.ackId) : $past(st_r.intId));
  endproperty
  a_code_form: assert property (p_code_form) else $error("end-point code badly formed"); // R1 R2 R23

  property p_int_note;
    @(posedge clk_sys) disable iff (srst)
      ndRxValid && enabled && st_r.ctrl[dir_pkg::CTRL_NODE_RECV] && ndRxCode.kind == dir_pkg::BC_KIND_IRQ
        && !ndRxCode.ack |=> hostIntNote && hostNoteId == $past(ndRxCode.id);
  endproperty
  a_int_note: assert property (p_int_note) else $error("received interrupt not reported"); // R6

  property p_ack_note;
    @(posedge clk_sys) disable iff (srst)
      ndRxValid && enabled && ackMode && st_r.ctrl[dir_pkg::CTRL_NODE_ARECV]
        && ndRxCode.kind == dir_pkg::BC_KIND_IRQ && ndRxCode.ack
        |=> hostAckNote && !hostIntNote && hostNoteId == $past(ndRxCode.id);
  endproperty
  a_ack_note: assert property (p_ack_note) else $error("received ack not reported"); // R22

  property p_ack_send;
    @(posedge clk_sys) disable iff (srst)
      hostAckReq && !st_r.ackPend && enabled && ackMode && st_r.ctrl[dir_pkg::CTRL_NODE_ASEND]
        |=> hostAckBusy && st_r.ackId == $past(hostAckId);
  endproperty
  a_ack_send: assert property (p_ack_send) else $error("host ack request not taken"); // R20

  property p_ack_off;
    @(posedge clk_sys) disable iff (srst)
      hostAckReq && !st_r.ackPend && !(enabled && ackMode && st_r.ctrl[dir_pkg::CTRL_NODE_ASEND])
        |=> !hostAckBusy;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("ack request taken while ack sending off"); // R20

  property p_disabled;
    @(posedge clk_sys) disable iff (srst)
      !enabled && !st_r.dWrite |=> txValid == '0 && !hostIntNote && !hostAckNote && !st_r.intPend;
  endproperty
  a_disabled: assert property (p_disabled) else $error("activity while support disabled"); // R4

  property p_host_send;
    @(posedge clk_sys) disable iff (srst)
      hostIntReq && !st_r.intPend && !st_r.ackPend && enabled && st_r.ctrl[dir_pkg::CTRL_NODE_SEND]
        && !hostAckReq && !ndTxValid |=> ##1 ndTxValid && !ndTxCode.ack && ndTxCode.id == $past(hostIntId, 2);
  endproperty
  a_host_send: assert property (p_host_send) else $error("host interrupt not sent"); // R5

endmodule : dir_relay

/* File: verif/dir_link_model.sv */
// far-side link model: stalls end-point sends, records forwarded codes
`timescale 1ns/1ns
module dir_link_model (
  // clock
  input wire logic clk_sys,
  // end-point send side
  input wire logic ndTxValid,
  input wire dir_pkg::dir_code_s ndTxCode,
  output logic ndTxReady,
  // switch send side
  input wire logic [3:0] txValid,
  input wire dir_pkg::dir_code_s txCode,
  // wait cycles before taking a code
  input wire logic [3:0] stall
);
  logic [7:0] got[$];
  logic [3:0] waitCnt = 4'h0;
  logic [3:0] txMask = 4'h0;
  logic [7:0] txLast = 8'h00;
  int txPulses = 0;
  initial ndTxReady = 1'b0;
  always @(posedge clk_sys) begin
    if (ndTxValid && ndTxReady) begin
      got.push_back(ndTxCode);
      ndTxReady <= 1'b0;
      waitCnt <= 4'h0;
    end else if (ndTxValid) begin
      waitCnt <= waitCnt + 4'h1;
      ndTxReady <= (waitCnt >= stall);
    end
    if (|txValid) begin
      txPulses <= txPulses + 1;
      txMask <= txValid;
      txLast <= txCode;
    end
  end
endmodule : dir_link_model

/* File: verif/test_distributed_interrupt_relay.sv */
// self-checking bench of the interrupt relay
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_distributed_interrupt_relay;
  logic clk_sys, srst, hsel, hwrite, hostIntReq, hostAckReq, ndRxValid;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, ndTxValid, ndTxReady, hostIntBusy, hostAckBusy, hostIntNote, hostAckNote;
  logic [3:0] rxValid, rxReady, txValid, stall;
  dir_pkg::dir_code_s [3:0] rxCode;
  dir_pkg::dir_code_s txCode, ndTxCode, ndRxCode;
  logic [4:0] hostIntId, hostAckId, hostNoteId;
  int fails = 0;
  int compares = 0;

  dir_relay dut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rxValid(rxValid), .rxCode(rxCode), .rxReady(rxReady),
    .txValid(txValid), .txCode(txCode), .ndTxValid(ndTxValid), .ndTxCode(ndTxCode),
    .ndTxReady(ndTxReady), .ndRxValid(ndRxValid), .ndRxCode(ndRxCode), .hostIntReq(hostIntReq),
    .hostIntId(hostIntId), .hostAckReq(hostAckReq), .hostAckId(hostAckId), .hostIntBusy(hostIntBusy),
    .hostAckBusy(hostAckBusy), .hostIntNote(hostIntNote), .hostAckNote(hostAckNote),
    .hostNoteId(hostNoteId));
  dir_link_model lnk (.clk_sys(clk_sys), .ndTxValid(ndTxValid), .ndTxCode(ndTxCode),
    .ndTxReady(ndTxReady), .txValid(txValid), .txCode(txCode), .stall(stall));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task complete_run;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= dir_pkg::HSIZE_WORD;
    htrans <= dir_pkg::HTRANS_NONSEQ;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
    `CHK(hresp, dir_pkg::HRESP_OKAY)
  endtask : ahb

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task rdChk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rdChk

  task sendRx(input int p, input logic [7:0] c, input logic fwd, input logic [3:0] m);
    int n;
    n = lnk.txPulses;
    @(posedge clk_sys);
    rxValid[p] <= 1'b1;
    rxCode[p] <= c;
    do @(posedge clk_sys); while (rxReady[p] !== 1'b1);
    rxValid[p] <= 1'b0;
    rxCode[p] <= ~c;
    repeat (4) @(posedge clk_sys);
    `CHK(lnk.txPulses, n + int'(fwd))
    if (fwd) begin
      `CHK(lnk.txMask, m)
      `CHK(lnk.txLast, c)
    end
  endtask : sendRx

  task hostReq(input logic i, input logic a, input logic [4:0] ii, input logic [4:0] ai);
    @(posedge clk_sys);
    hostIntReq <= i;
    hostIntId <= ii;
    hostAckReq <= a;
    hostAckId <= ai;
    @(posedge clk_sys);
    hostIntReq <= 1'b0;
    hostAckReq <= 1'b0;
  endtask : hostReq

  task waitGot(input int n);
    for (int k = 0; k < 60 && lnk.got.size() < n; k++) @(posedge clk_sys);
    `CHK(lnk.got.size(), n)
  endtask : waitGot

  task ndRx(input logic [7:0] c, input logic ei, input logic ea);
    @(posedge clk_sys);
    ndRxValid <= 1'b1;
    ndRxCode <= c;
    @(posedge clk_sys);
    ndRxValid <= 1'b0;
    ndRxCode <= ~c;
    @(posedge clk_sys);
    `CHK(hostIntNote, ei)
    `CHK(hostAckNote, ea)
    if (ei || ea) `CHK(hostNoteId, c[4:0])
  endtask : ndRx

  task t_reset;
    rdChk(dir_pkg::REG_RELAY, 32'h0);
    rdChk(32'h0000_0020, 32'h0);
    rdChk(dir_pkg::REG_TMO_PLAIN, 32'(dir_pkg::TMO_DEF_CYC));
    rdChk(dir_pkg::REG_TMO_ACK, 32'(dir_pkg::TMO_DEF_CYC));
  endtask : t_reset

  task t_relay;
    wr(dir_pkg::REG_CTRL, 32'h0000_000D);
    rdChk(dir_pkg::REG_CTRL, 32'h0000_000D);
    wr(dir_pkg::REG_PORTEN, 32'h0007_0007);
    wr(dir_pkg::REG_TMO_PLAIN, 32'd60);
    wr(dir_pkg::REG_TMO_ACK, 32'd400);
    rdChk(dir_pkg::REG_TMO_ACK, 32'd400);
    sendRx(1, 8'h83, 1'b1, 4'h5);
    rdChk(dir_pkg::REG_RELAY, 32'h0000_0008);
    sendRx(0, 8'h83, 1'b0, 4'h0);
    sendRx(3, 8'h86, 1'b0, 4'h0);
    sendRx(0, 8'hA4, 1'b0, 4'h0);
    sendRx(0, 8'h04, 1'b0, 4'h0);
    repeat (70) @(posedge clk_sys);
    rdChk(dir_pkg::REG_RELAY, 32'h0);
    sendRx(0, 8'h83, 1'b1, 4'h6);
    sendRx(2, 8'h9F, 1'b1, 4'h3);
    rdChk(dir_pkg::REG_RELAY, 32'h8000_0008);
  endtask : t_relay

  task t_node;
    wr(dir_pkg::REG_CTRL, 32'h0000_003F);
    stall <= 4'h3;
    hostReq(1'b1, 1'b0, 5'h05, 5'h00);
    @(posedge clk_sys);
    `CHK(hostIntBusy, 1'b1)
    waitGot(1);
    `CHK(lnk.got[0], 8'h85)
    hostReq(1'b1, 1'b1, 5'h01, 5'h02);
    @(posedge clk_sys);
    `CHK(hostAckBusy, 1'b1)
    `CHK(hostIntBusy, 1'b1)
    waitGot(3);
    `CHK(lnk.got[1], 8'hA2)
    `CHK(lnk.got[2], 8'h81)
    ndRx(8'h89, 1'b1, 1'b0);
    ndRx(8'hA9, 1'b0, 1'b1);
    sendRx(0, 8'h87, 1'b1, 4'h6);
    repeat (70) @(posedge clk_sys);
    rdChk(dir_pkg::REG_RELAY, 32'h0000_0080);
  endtask : t_node

  task t_off;
    wr(dir_pkg::REG_CTRL, 32'h0);
    lnk.got.delete();
    hostReq(1'b1, 1'b1, 5'h03, 5'h03);
    @(posedge clk_sys);
    `CHK(hostIntBusy, 1'b0)
    `CHK(hostAckBusy, 1'b0)
    repeat (12) @(posedge clk_sys);
    `CHK(lnk.got.size(), 0)
    ndRx(8'h8A, 1'b0, 1'b0);
    sendRx(0, 8'h85, 1'b0, 4'h0);
  endtask : t_off

  initial begin
    srst <= 1'b1;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= dir_pkg::HSIZE_WORD;
    hwdata <= 32'h0;
    rxValid <= 4'h0;
    rxCode <= '0;
    ndRxValid <= 1'b0;
    ndRxCode <= 8'h00;
    hostIntReq <= 1'b0;
    hostAckReq <= 1'b0;
    hostIntId <= 5'h00;
    hostAckId <= 5'h00;
    stall <= 4'h0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_relay();
    t_node();
    t_off();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule : test_distributed_interrupt_relay
